// ===== scx_top.sv
// tone-call decoder, FFSK receiver and transmit modulator control with Avalon-MM registers
`include "scx_regs.svh"
module scx_top #(
    parameter int BIT_CYCLES_LOW  = `SCX_CLK_HZ / `SCX_BAUD_LOW,
    parameter int BIT_CYCLES_HIGH = `SCX_CLK_HZ / `SCX_BAUD_HIGH
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire scx_pkg::scx_avl_req_type   avlReq,
    output scx_pkg::scx_avl_rsp_type        avlRsp,
    input  wire scx_pkg::scx_tone_meas_type toneMeas,
    input  wire logic                       rxSlice,
    input  wire logic                       rxRate2400,
    input  wire logic [7:0]                 subAudioIn,
    input  wire logic [7:0]                 voiceBandIn,
    output logic [7:0]                      modulatorOutA,
    output logic [7:0]                      modulatorOutB,
    output logic                            modAOeN,
    output logic                            modBOeN,
    output logic                            txActive,
    output scx_pkg::scx_sub_type            subAudioSel,
    output scx_pkg::scx_vb_type             voiceBandSel,
    output logic                            toneIrq,
    output logic                            dataIrq,
    output logic                            syncIrq
);
    localparam logic [13:0] PERIOD_LOW  = 14'(BIT_CYCLES_LOW);
    localparam logic [13:0] PERIOD_HIGH = 14'(BIT_CYCLES_HIGH);
    localparam logic [15:0] RAMP_STEP   = 16'(`SCX_RAMP_STEP_CYC);

    typedef struct packed {
        logic                      waitrequest;
        logic [31:0]               readdata;
        logic [15:0]               ctrl;
        logic [4:0]                toneCode;
        logic                      tonePend;
        logic [3:0]                events;
        logic [7:0]                rxByte;
        logic [15:0]               syncPri;
        logic [15:0]               syncSec;
        logic [7:0]                bandwidth;
        logic [7:0]                threshold;
        logic [7:0]                rampRate;
        logic [7:0]                gainA;
        logic [7:0]                gainB;
        logic [15:0][15:0]         toneTable;
        logic [13:0]               phase;
        logic                      lastSlice;
        logic [15:0]               shift;
        logic [2:0]                bitCnt;
        scx_pkg::scx_tx_state_type txState;
        logic                      txActive;
        logic [7:0]                ramp;
        logic [15:0]               rampCnt;
        logic [7:0]                modA;
        logic [7:0]                modB;
        logic                      modAOeN;
        logic                      modBOeN;
        scx_pkg::scx_sub_type      subSel;
        scx_pkg::scx_vb_type       vbSel;
        logic                      toneIrq;
        logic                      dataIrq;
        logic                      syncIrq;
    } scx_top_state_type;

    scx_top_state_type st;
    scx_top_state_type next_st;
    logic [3:0]        entryIdx;
    logic              scanDone;
    logic [4:0]        scanCode;

    scx_tone_scan u_scan (
        .clk       (clk),
        .rst_n     (rst_n),
        .meas      (toneMeas),
        .bandwidth (st.bandwidth),
        .threshold (st.threshold),
        .entry     (st.toneTable[entryIdx]),
        .entryIdx  (entryIdx),
        .done      (scanDone),
        .code      (scanCode)
    );

    // a tone counts as valid unless it is silence or unrecognised
    function automatic logic toneValid(input logic [4:0] c);
        toneValid = (c != 5'h00) && (c[3:0] != 4'hf);
    endfunction

    // bias plus sample scaled by gain and ramp envelope, saturated
    function automatic logic [7:0] scaleOut(input logic signed [8:0] s,
                                            input logic [7:0] gain,
                                            input logic [7:0] env);
        logic signed [17:0] p1;
        logic signed [18:0] p2;
        logic signed [10:0] v;
        p1 = 18'(s) * 18'($signed({1'b0, gain}));
        p2 = 19'($signed(p1[16:8])) * 19'($signed({1'b0, env}));
        v = 11'($signed(p2[18:8])) + 11'sd128;
        if (v < 11'sd0) begin
            scaleOut = 8'h00;
        end else if (v > 11'sd255) begin
            scaleOut = 8'hff;
        end else begin
            scaleOut = v[7:0];
        end
    endfunction

    logic               accept;
    logic               wrAcc;
    logic               rdAcc;
    logic [13:0]        period;
    logic               rateOk;
    logic               sampleBit;
    logic [15:0]        newShift;
    logic [15:0]        rampLimit;
    logic               rampTick;
    logic signed [8:0]  subTerm;
    logic signed [8:0]  vbTerm;
    logic signed [8:0]  composite;
    logic [3:0]         evClear;
    logic [3:0]         evSet;
    logic [31:0]        rdValue;
    logic [5:0]         tblIdx;

    always_comb begin
        next_st = st;
        next_st.toneIrq = 1'b0;
        next_st.dataIrq = 1'b0;
        next_st.syncIrq = 1'b0;
        evClear = 4'h0;
        evSet = 4'h0;
        tblIdx = 6'((avlReq.address - `SCX_OFS_TONE_BASE) >> 2);

        // bus: first edge loads read data and drops waitrequest, second completes
        accept = (avlReq.read || avlReq.write) && !st.waitrequest;
        wrAcc = accept && avlReq.write;
        rdAcc = accept && avlReq.read;
        rdValue = 32'h0;
        if (avlReq.address == `SCX_OFS_CTRL) begin
            rdValue = {16'h0, st.ctrl};
        end else if (avlReq.address == `SCX_OFS_TONE_STATUS) begin
            rdValue = {27'h0, st.toneCode};
        end else if (avlReq.address == `SCX_OFS_EVENT) begin
            rdValue = {28'h0, st.events};
        end else if (avlReq.address == `SCX_OFS_RX_DATA) begin
            rdValue = {24'h0, st.rxByte};
        end else if (avlReq.address == `SCX_OFS_SYNC_PRI) begin
            rdValue = {16'h0, st.syncPri};
        end else if (avlReq.address == `SCX_OFS_SYNC_SEC) begin
            rdValue = {16'h0, st.syncSec};
        end else if (avlReq.address == `SCX_OFS_DETECT) begin
            rdValue = {16'h0, st.threshold, st.bandwidth};
        end else if (avlReq.address == `SCX_OFS_RAMP) begin
            rdValue = {24'h0, st.rampRate};
        end else if (avlReq.address == `SCX_OFS_GAIN) begin
            rdValue = {16'h0, st.gainB, st.gainA};
        end else if (avlReq.address[7:6] == 2'b01 && avlReq.address[1:0] == 2'b00) begin
            rdValue = {16'h0, st.toneTable[tblIdx[3:0]]};
        end
        if ((avlReq.read || avlReq.write) && st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            next_st.readdata = avlReq.read ? rdValue : 32'h0;
        end else begin
            next_st.waitrequest = 1'b1;
        end

        if (wrAcc) begin
            if (avlReq.address == `SCX_OFS_CTRL) begin
                next_st.ctrl = avlReq.writedata[15:0];
            end else if (avlReq.address == `SCX_OFS_EVENT) begin
                evClear = avlReq.writedata[3:0];
            end else if (avlReq.address == `SCX_OFS_SYNC_PRI) begin
                next_st.syncPri = avlReq.writedata[15:0];
            end else if (avlReq.address == `SCX_OFS_SYNC_SEC) begin
                next_st.syncSec = avlReq.writedata[15:0];
            end else if (avlReq.address == `SCX_OFS_CMD) begin
                if (avlReq.writedata[`SCX_CMD_RESET]) begin
                    next_st.syncPri = `SCX_SYNC_RESET;
                    next_st.syncSec = `SCX_SYNC_RESET;
                end
            end else if (avlReq.address == `SCX_OFS_DETECT) begin
                next_st.bandwidth = avlReq.writedata[7:0];
                next_st.threshold = avlReq.writedata[15:8];
            end else if (avlReq.address == `SCX_OFS_RAMP) begin
                next_st.rampRate = avlReq.writedata[7:0];
            end else if (avlReq.address == `SCX_OFS_GAIN) begin
                next_st.gainA = avlReq.writedata[7:0];
                next_st.gainB = avlReq.writedata[15:8];
            end else if (avlReq.address[7:6] == 2'b01 && avlReq.address[1:0] == 2'b00) begin
                next_st.toneTable[tblIdx[3:0]] = avlReq.writedata[15:0];
            end
        end
        if (rdAcc && avlReq.address == `SCX_OFS_RX_DATA) begin
            evClear[`SCX_EV_DATA] = 1'b1;
        end

        // code lands in the status register one cycle ahead of its event
        next_st.tonePend = 1'b0;
        if (scanDone && scanCode != st.toneCode) begin
            next_st.toneCode = scanCode;
            next_st.tonePend = toneValid(scanCode) || toneValid(st.toneCode);
        end
        if (st.tonePend && st.ctrl[`SCX_CTRL_TONE_IRQ]) begin
            evSet[`SCX_EV_TONE] = 1'b1;
            next_st.toneIrq = 1'b1;
        end

        // receiver: a fixed rate ignores signals at the other rate
        rateOk = !st.ctrl[`SCX_CTRL_RATE_FIXED] ||
                 (rxRate2400 == st.ctrl[`SCX_CTRL_RATE_2400]);
        period = (st.ctrl[`SCX_CTRL_RATE_FIXED] ? st.ctrl[`SCX_CTRL_RATE_2400] : rxRate2400)
                 ? PERIOD_HIGH : PERIOD_LOW;
        sampleBit = 1'b0;
        newShift = {st.shift[14:0], rxSlice};
        if (!st.ctrl[`SCX_CTRL_MSK_EN] || !rateOk) begin
            next_st.phase = 14'h0;
            next_st.bitCnt = 3'h0;
            next_st.lastSlice = rxSlice;
        end else begin
            // bit loop: transitions realign phase, mid-bit samples data
            next_st.lastSlice = rxSlice;
            if (rxSlice != st.lastSlice) begin
                next_st.phase = 14'h0;
            end else if (st.phase >= period - 14'h1) begin
                next_st.phase = 14'h0;
            end else begin
                next_st.phase = st.phase + 14'h1;
            end
            sampleBit = (rxSlice == st.lastSlice) && (st.phase == (period >> 1));
        end
        if (sampleBit) begin
            next_st.shift = newShift;
            next_st.bitCnt = st.bitCnt + 3'h1;
            if (st.bitCnt == 3'h7) begin
                next_st.rxByte = newShift[7:0];
                evSet[`SCX_EV_DATA] = 1'b1;
                evSet[`SCX_EV_OVERRUN] = st.events[`SCX_EV_DATA] &&
                                         !evClear[`SCX_EV_DATA];
                next_st.dataIrq = 1'b1;
            end
            if (newShift == st.syncPri || newShift == st.syncSec ||
                newShift == ~st.syncPri) begin
                evSet[`SCX_EV_SYNC] = 1'b1;
                next_st.syncIrq = 1'b1;
                next_st.bitCnt = 3'h0;
            end
        end
        // a new event wins over a clear landing in the same cycle
        next_st.events = (st.events & ~evClear) | evSet;

        // signal selection follows the control word one cycle later, unused codes select none
        next_st.subSel = scx_pkg::scx_sub_type'(st.ctrl[`SCX_CTRL_SUB_LSB +: 2]);
        if (st.ctrl[`SCX_CTRL_SUB_LSB +: 2] == 2'b11) begin
            next_st.subSel = scx_pkg::SCX_SUB_NONE;
        end
        next_st.vbSel = scx_pkg::scx_vb_type'(st.ctrl[`SCX_CTRL_VB_LSB +: 3]);
        if (st.ctrl[`SCX_CTRL_VB_LSB +: 3] > 3'h4) begin
            next_st.vbSel = scx_pkg::SCX_VB_NONE;
        end

        // ramp envelope: one step per tick, tick length from the ramp word
        rampLimit = 16'(({8'h00, st.rampRate} + 16'h1) * RAMP_STEP);
        rampTick = (st.rampCnt >= rampLimit - 16'h1);
        next_st.rampCnt = rampTick ? 16'h0 : st.rampCnt + 16'h1;
        case (st.txState)
            scx_pkg::SCX_RX: begin
                next_st.ramp = 8'h00;
                next_st.rampCnt = 16'h0;
                if (st.ctrl[`SCX_CTRL_TX_EN]) begin
                    next_st.txState = scx_pkg::SCX_RAMP_UP;
                end
            end
            scx_pkg::SCX_RAMP_UP: begin
                if (!st.ctrl[`SCX_CTRL_TX_EN]) begin
                    next_st.txState = scx_pkg::SCX_RAMP_DOWN;
                end else if (st.ramp == 8'hff) begin
                    next_st.txState = scx_pkg::SCX_TX;
                end else if (rampTick) begin
                    next_st.ramp = st.ramp + 8'h1;
                end
            end
            scx_pkg::SCX_TX: begin
                if (!st.ctrl[`SCX_CTRL_TX_EN]) begin
                    next_st.txState = scx_pkg::SCX_RAMP_DOWN;
                end
            end
            scx_pkg::SCX_RAMP_DOWN: begin
                if (st.ramp == 8'h00) begin
                    next_st.txState = scx_pkg::SCX_RX;
                end else if (rampTick) begin
                    next_st.ramp = st.ramp - 8'h1;
                end
            end
            default: begin
                next_st.txState = scx_pkg::SCX_RX;
            end
        endcase
        // flag and selection registered together, so never out of step
        next_st.txActive = (next_st.txState != scx_pkg::SCX_RX);
        if (!next_st.txActive) begin
            next_st.subSel = scx_pkg::SCX_SUB_NONE;
            next_st.vbSel = scx_pkg::SCX_VB_NONE;
        end

        subTerm = (st.subSel != scx_pkg::SCX_SUB_NONE) ?
                  9'($signed(subAudioIn)) : 9'sd0;
        vbTerm = (st.vbSel != scx_pkg::SCX_VB_NONE) ?
                 9'($signed(voiceBandIn)) : 9'sd0;
        composite = subTerm + vbTerm;
        next_st.modA = st.ctrl[`SCX_CTRL_MODA_EN] ?
                       scaleOut(composite, st.gainA, st.ramp) : `SCX_BIAS;
        next_st.modB = st.ctrl[`SCX_CTRL_MODB_EN] ?
                       scaleOut(composite, st.gainB, st.ramp) : `SCX_BIAS;
        next_st.modAOeN = !st.ctrl[`SCX_CTRL_MODA_PWR];
        next_st.modBOeN = !st.ctrl[`SCX_CTRL_MODB_PWR];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.waitrequest <= 1'b1;
            st.ctrl <= `SCX_CTRL_RESET;
            st.syncPri <= `SCX_SYNC_RESET;
            st.syncSec <= `SCX_SYNC_RESET;
            st.gainA <= `SCX_GAIN_RESET;
            st.gainB <= `SCX_GAIN_RESET;
            st.modA <= `SCX_BIAS;
            st.modB <= `SCX_BIAS;
            st.modAOeN <= 1'b1;
            st.modBOeN <= 1'b1;
            st.txState <= scx_pkg::SCX_RX;
        end else begin
            st <= next_st;
        end
    end

    assign avlRsp.readdata    = st.readdata;
    assign avlRsp.waitrequest = st.waitrequest;
    assign modulatorOutA      = st.modA;
    assign modulatorOutB      = st.modB;
    assign modAOeN            = st.modAOeN;
    assign modBOeN            = st.modBOeN;
    assign txActive           = st.txActive;
    assign subAudioSel        = st.subSel;
    assign voiceBandSel       = st.vbSel;
    assign toneIrq            = st.toneIrq;
    assign dataIrq            = st.dataIrq;
    assign syncIrq            = st.syncIrq;
endmodule

// ===== scx_regs.svh
// register offsets, field positions, reset values and timing counts of the signalling block
`ifndef SCX_REGS_SVH
`define SCX_REGS_SVH
`define SCX_OFS_CTRL        8'h00
`define SCX_OFS_TONE_STATUS 8'h04
`define SCX_OFS_EVENT       8'h08
`define SCX_OFS_RX_DATA     8'h0c
`define SCX_OFS_SYNC_PRI    8'h10
`define SCX_OFS_SYNC_SEC    8'h14
`define SCX_OFS_CMD         8'h18
`define SCX_OFS_DETECT      8'h1c
`define SCX_OFS_RAMP        8'h20
`define SCX_OFS_GAIN        8'h24
`define SCX_OFS_TONE_BASE   8'h40
`define SCX_CTRL_TONE_IRQ   0
`define SCX_CTRL_MSK_EN     1
`define SCX_CTRL_RATE_FIXED 2
`define SCX_CTRL_RATE_2400  3
`define SCX_CTRL_MODA_EN    4
`define SCX_CTRL_MODB_EN    5
`define SCX_CTRL_MODA_PWR   6
`define SCX_CTRL_MODB_PWR   7
`define SCX_CTRL_TX_EN      8
`define SCX_CTRL_SUB_LSB    9
`define SCX_CTRL_VB_LSB     12
`define SCX_EV_TONE         0
`define SCX_EV_DATA         1
`define SCX_EV_SYNC         2
`define SCX_EV_OVERRUN      3
`define SCX_CMD_RESET       0
`define SCX_SYNC_RESET      16'hc4d7
`define SCX_BIAS            8'h80
`define SCX_GAIN_RESET      8'h80
`define SCX_CTRL_RESET      16'h0000
`define SCX_CLK_HZ          10000000
`define SCX_BAUD_LOW        1200
`define SCX_BAUD_HIGH       2400
`define SCX_RAMP_STEP_NS    1000
`define SCX_CLK_NS          100
`define SCX_RAMP_STEP_CYC   (`SCX_RAMP_STEP_NS / `SCX_CLK_NS)
`endif

// ===== scx_pkg.sv
// types shared by the signalling block
package scx_pkg;
    typedef enum logic [1:0] {
        SCX_RX        = 2'b00,
        SCX_RAMP_UP   = 2'b01,
        SCX_TX        = 2'b10,
        SCX_RAMP_DOWN = 2'b11
    } scx_tx_state_type;
    typedef enum logic [1:0] {
        SCX_SUB_NONE  = 2'b00,
        SCX_SUB_CTCSS = 2'b01,
        SCX_SUB_DCS   = 2'b10
    } scx_sub_type;
    typedef enum logic [2:0] {
        SCX_VB_NONE    = 3'b000,
        SCX_VB_VOICE   = 3'b001,
        SCX_VB_SELCALL = 3'b010,
        SCX_VB_FFSK    = 3'b011,
        SCX_VB_DTMF    = 3'b100
    } scx_vb_type;
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } scx_avl_req_type;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } scx_avl_rsp_type;
    typedef struct packed {
        logic        start;
        logic [15:0] freq;
        logic [7:0]  level;
    } scx_tone_meas_type;
endpackage

// ===== scx_tone_scan.sv
// sequential tone-table scanner producing a five-bit tone code
module scx_tone_scan (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire scx_pkg::scx_tone_meas_type meas,
    input  wire logic [7:0]                 bandwidth,
    input  wire logic [7:0]                 threshold,
    input  wire logic [15:0]                entry,
    output logic [3:0]                      entryIdx,
    output logic                            done,
    output logic [4:0]                      code
);
    typedef struct packed {
        logic        busy;
        logic [3:0]  idx;
        logic        done;
        logic [4:0]  code;
        logic [15:0] freq;
    } scx_scan_state_type;

    scx_scan_state_type st;
    scx_scan_state_type next_st;
    logic [15:0]        diff;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        diff = (st.freq > entry) ? st.freq - entry : entry - st.freq;
        if (!st.busy) begin
            if (meas.start) begin
                if (meas.level < threshold) begin
                    next_st.done = 1'b1;
                    next_st.code = 5'h00;
                end else begin
                    next_st.busy = 1'b1;
                    next_st.idx = 4'h0;
                    next_st.freq = meas.freq;
                end
            end
        end else begin
            // entries 0..14 are normal codes, entry 15 the repeat tone
            if (diff <= {8'h00, bandwidth}) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.code = (st.idx == 4'hf) ? 5'h0e : {1'b1, st.idx};
            end else if (st.idx == 4'hf) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.code = 5'h0f;
            end else begin
                next_st.idx = st.idx + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign entryIdx = st.idx;
    assign done     = st.done;
    assign code     = st.code;
endmodule

// ===== scx_monitor.sv
// assertion checker for the signalling block ports
module scx_monitor (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire scx_pkg::scx_avl_req_type avlReq,
    input wire scx_pkg::scx_avl_rsp_type avlRsp,
    input wire logic [7:0]               modulatorOutA,
    input wire logic [7:0]               modulatorOutB,
    input wire logic                     txActive,
    input wire scx_pkg::scx_sub_type     subAudioSel,
    input wire scx_pkg::scx_vb_type      voiceBandSel,
    input wire logic                     toneIrq,
    input wire logic                     dataIrq,
    input wire logic                     syncIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    bus_wait_a: assert property ($rose(avlReq.read | avlReq.write) |=> !avlRsp.waitrequest)
        else $error("no answer after one wait state");
    bus_answer_a: assert property (!avlRsp.waitrequest |=> avlRsp.waitrequest)
        else $error("waitrequest low too long");
    rx_sel_a: assert property (!txActive |->
        subAudioSel == scx_pkg::SCX_SUB_NONE && voiceBandSel == scx_pkg::SCX_VB_NONE)
        else $error("signal selected outside transmit");
    vb_legal_a: assert property (voiceBandSel <= scx_pkg::SCX_VB_DTMF && subAudioSel != 2'b11)
        else $error("illegal signal combination");
    idle_bias_a: assert property (!txActive && $past(!txActive) |->
        modulatorOutA == 8'h80 && modulatorOutB == 8'h80)
        else $error("modulator not at bias in receive");
    tone_pulse_a: assert property (toneIrq |=> !toneIrq)
        else $error("tone event longer than one cycle");
    data_pulse_a: assert property (dataIrq |=> !dataIrq)
        else $error("data event longer than one cycle");
    sync_pulse_a: assert property (syncIrq |=> !syncIrq)
        else $error("sync event longer than one cycle");
endmodule
bind scx_top scx_monitor u_scx_monitor (.clk, .rst_n, .avlReq, .avlRsp, .modulatorOutA,
    .modulatorOutB, .txActive, .subAudioSel, .voiceBandSel, .toneIrq, .dataIrq, .syncIrq);

// ===== scx_host.sv
// host model: register bus master of the signalling block
module scx_host (
    input  wire logic                     clk,
    input  wire scx_pkg::scx_avl_rsp_type avlRsp,
    output scx_pkg::scx_avl_req_type      avlReq,
    output logic                          hang
);
    initial begin
        avlReq = '0;
        hang = 1'b0;
    end
    // callers load every setting before the enable word
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk);
        avlReq <= '{~wr, wr, a, d};
        q = '0;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avlRsp.waitrequest === 1'b0) begin
                q = avlRsp.readdata;
                break;
            end
        end
        if (n == 50) hang = 1'b1;
        avlReq <= '0;
    endtask
endmodule

// ===== testbench.sv
// self-checking bench for the signalling block
`include "scx_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BC = 40;
    logic                       clk, rst_n, rxSlice, rxRate2400, toneIrq, dataIrq, syncIrq;
    logic                       oeA, oeB, txActive, hang;
    logic [7:0]                 subAudioIn, voiceBandIn, outA, outB;
    logic [31:0]                q, d;
    logic [15:0]                pat;
    scx_pkg::scx_avl_req_type   avlReq;
    scx_pkg::scx_avl_rsp_type   avlRsp;
    scx_pkg::scx_tone_meas_type toneMeas;
    scx_pkg::scx_sub_type       subSel;
    scx_pkg::scx_vb_type        vbSel;
    int                         err_total, n_tests, seed, k, i, j, w, nTone, nSync, nData, wd;
    scx_top #(.BIT_CYCLES_LOW(BC), .BIT_CYCLES_HIGH(BC / 2)) u_scx_top (.clk, .rst_n, .avlReq,
        .avlRsp, .toneMeas, .rxSlice, .rxRate2400, .subAudioIn, .voiceBandIn,
        .modulatorOutA(outA), .modulatorOutB(outB), .modAOeN(oeA), .modBOeN(oeB), .txActive,
        .subAudioSel(subSel), .voiceBandSel(vbSel), .toneIrq, .dataIrq, .syncIrq);
    scx_host u_scx_host (.clk, .avlRsp, .avlReq, .hang);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        nTone <= nTone + int'(toneIrq);
        nSync <= nSync + int'(syncIrq);
        nData <= nData + int'(dataIrq);
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // code for stimulus index c; 16 hits no table entry
    function automatic logic [31:0] expCode(input int c);
        return c == 16 ? 32'h0f : c == 15 ? 32'h0e : 32'h10 + 32'(c);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_scx_host.xfer(1'b1, a, v, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_scx_host.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic meas(input logic [15:0] f, input logic [7:0] l);
        @(posedge clk);
        toneMeas <= '{1'b1, f, l};
        @(posedge clk);
        toneMeas.start <= 1'b0;
    endtask
    task automatic sendBits(input logic [15:0] v);
        for (int b = 15; b >= 0; b--) begin
            rxSlice <= v[b];
            repeat (BC) @(posedge clk);
        end
    endtask
    task automatic conclude;
        if (hang) err_total++;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        conclude();
    end
    initial begin
        seed = 89439;
        {rst_n, rxSlice, rxRate2400, subAudioIn, voiceBandIn, toneMeas} = '0;
        {err_total, n_tests, nTone, nSync, nData} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 3; i++) begin
                rd(i == 2 ? 8'h3c : 8'h10 + 8'(i * 4));
                chk("sync_word", i == 2 ? 32'h0 : 32'hc4d7, q);
                wr(i == 2 ? 8'h3c : 8'h10 + 8'(i * 4), $random(seed));
            end
            wr(`SCX_OFS_CMD, 32'h1);
        end
        $display("test registers done");
        for (i = 0; i < 16; i++)
            wr(`SCX_OFS_TONE_BASE + 8'(i * 4), 32'h400 + i * 32'h40);
        wr(`SCX_OFS_DETECT, 32'h1008);
        wr(`SCX_OFS_CTRL, 32'h1);
        k = 0;
        for (i = 0; i < 5; i++) begin
            k = (i == 4) ? 16 : (k + 1 + int'($unsigned($random(seed)) % 15)) % 16;
            w = nTone + 1;
            meas(k == 16 ? 16'h0100 : 16'h0400 + 16'(k * 64), 8'h40);
            for (j = 0; j < 60 && nTone < w; j++) @(posedge clk);
            chk("tone_event", w, nTone);
            rd(`SCX_OFS_TONE_STATUS);
            chk("tone_code", expCode(k), q);
        end
        meas(16'h0400, 8'h01);
        repeat (40) @(posedge clk);
        rd(`SCX_OFS_TONE_STATUS);
        chk("no_tone", 32'h0, q);
        chk("quiet_event", w, nTone);
        $display("test tone done");
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            pat = i == 0 ? 16'hc4d7 : i == 1 ? 16'h3b28 : d[31:16];
            w = nSync;
            wd = nData;
            wr(`SCX_OFS_SYNC_SEC, {16'h0, d[31:16]});
            wr(`SCX_OFS_CTRL, i == 3 ? 32'he : i == 2 ? 32'h6 : 32'h2);
            sendBits(pat);
            sendBits({d[7:0], d[15:8]});
            wr(`SCX_OFS_CTRL, 32'h0);
            chk("sync_match", i == 3 ? w : w + 1, nSync);
            chk("data_event", i == 3 ? 0 : 4, nData - wd);
            rd(`SCX_OFS_EVENT);
            if (i < 3) chk("overrun", 32'h1, {31'h0, q[3]});
            rd(`SCX_OFS_RX_DATA);
            if (i < 3) chk("rx_byte", {24'h0, d[15:8]}, q);
            wr(`SCX_OFS_EVENT, 32'hf);
        end
        $display("test receive done");
        // both samples non-negative so the sum cannot cancel to bias
        voiceBandIn <= 8'($random(seed)) & 8'h3f | 8'h40;
        subAudioIn <= 8'($random(seed)) & 8'h1f;
        wr(`SCX_OFS_GAIN, 32'hffff);
        wr(`SCX_OFS_RAMP, 32'h0);
        wr(`SCX_OFS_CTRL, 32'h13f0);
        for (j = 0; j < 5 && txActive !== 1'b1; j++) @(posedge clk);
        chk("ramp_start", 32'h1,
            {31'h0, txActive === 1'b1 && outA inside {8'h7f, 8'h80, 8'h81}});
        repeat (2700) @(posedge clk);
        chk("sels", {27'h0, subSel, vbSel}, {27'h0, scx_pkg::SCX_SUB_CTCSS, scx_pkg::SCX_VB_VOICE});
        chk("mod_live", 32'h1, {31'h0, outA !== 8'h80 && oeA === 1'b0});
        wr(`SCX_OFS_CTRL, 32'h13e0);
        repeat (3) @(posedge clk);
        chk("mod_off_bias", 32'h80, {24'h0, outA});
        wr(`SCX_OFS_CTRL, 32'h00a0);
        for (j = 0; j < 3000 && txActive !== 1'b0; j++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("ramp_end", 32'h280, {21'h0, txActive, oeA, oeB, outB});
        $display("test transmit done");
        conclude();
    end
endmodule
